// >>> hw/bkreg_consts.svh
`ifndef BKREG_CONSTS_SVH
`define BKREG_CONSTS_SVH

// ----------------------------------------------------------------------
// serial target address and register offsets
// ----------------------------------------------------------------------
`define BKREG_TARGET_ADDR   7'h40
`define BKREG_OFS_TGT_LOW   8'h01
`define BKREG_OFS_TGT_HIGH  8'h02
`define BKREG_OFS_MISC_CFG  8'h03
`define BKREG_OFS_EVENTS    8'h05

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BKREG_RST_TGT_LOW   7'h10
`define BKREG_RST_TGT_HIGH  8'h38
`define BKREG_RST_MISC_CFG  7'h6b
`define BKREG_RST_EVENTS    8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BKREG_CFG_RESET_BIT 7
`define BKREG_CFG_FCS_DVS   6
`define BKREG_CFG_SW_EN     5
`define BKREG_CFG_FCS       4
`define BKREG_CFG_DISCH_EN  3
`define BKREG_HIGH_FCS_BIT  7
`define BKREG_EVT_THERMAL   4
`define BKREG_EVT_PWR_BAD   2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BKREG_CLK_PERIOD_NS 5
`define BKREG_STARTUP_DELAY_US 250
`define BKREG_STARTUP_CYC   ((`BKREG_STARTUP_DELAY_US * 1000 + `BKREG_CLK_PERIOD_NS - 1) / `BKREG_CLK_PERIOD_NS)

`endif

// >>> hw/bkreg_pkg.sv
package bkreg_pkg;

  // ----------------------------------------------------------------------
  // serial engine states
  // ----------------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_PTR      = 9'h008,
    ST_PTR_ACK  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_WDAT_ACK = 9'h040,
    ST_RDATA    = 9'h080,
    ST_RACK     = 9'h100
  } bkreg_i2c_st_t;

  // pins and analog indications that cross into clk_sys
  typedef struct packed {
    logic scl;
    logic sda;
    logic enable;
    logic supplyLow;
    logic deepSupplyLoss;
    logic levelSelect;
    logic hsLimitTrip;
    logic lsBelowLimit;
    logic thermalTrip;
    logic skipMode;
    logic pwmHighReq;
    logic powerBad;
  } bkreg_ana_t;

  // complete state of the block
  typedef struct packed {
    bkreg_ana_t    s1;
    bkreg_ana_t    s2;
    bkreg_ana_t    prev;
    bkreg_i2c_st_t st;
    logic [3:0]    bitCnt;
    logic [7:0]    shIn;
    logic [7:0]    shOut;
    logic [7:0]    ptr;
    logic          rdDir;
    logic          sdaOe;
    logic [6:0]    tgtLow;
    logic [7:0]    tgtHigh;
    logic [6:0]    cfg;
    logic [7:0]    events;
    logic [16:0]   dlyCnt;
    logic          started;
    logic          everEn;
    logic          dischLat;
    logic          limAct;
    logic          thermOff;
    logic          hsOn;
    logic          lsOn;
    logic          dischOn;
    logic          softStart;
    logic [6:0]    actCode;
    logic          fcs;
    logic          run;
  } bkreg_state_t;

endpackage

// >>> hw/bkreg_i2c_ctrl.sv
`timescale 1ns/1ps
`include "bkreg_consts.svh"

// Summary of operation
// - answer only to fixed 7-bit address 0x40 with direction bit.
// - works at 100k, 400k and 1M bit rates, one protocol.
// - SDA falling while SCL high is a START; address byte follows.
// - on address match pull SDA low through ninth clock; else silent.
// - receiver of each byte acknowledges; byte groups may run on.
// - after every received byte pull SDA low for one clock.
// - byte after address is the register pointer; all eight bits select.
// - written byte commits at falling edge ending its acknowledge.
// - reading an unmapped pointer returns zero.
// - STOP releases bus, ends transfer, waits for next START.
// - enable falling edge resets registers; discharge choice stays latched.
// - reset bit restores defaults, restarts start-up; writes blocked during delay.
// - supply-low indication resets registers, otherwise contents kept.
// - first target code is 7 bits, default 0x10.
// - event flags register resets to zero and clears on read.
// - high-side limit trip swaps to low side until current falls.
// - thermal trip turns both switches off; recovery soft starts; skip mode exempt.
// - discharge engages when disabled, only after one enable since power-up.
// - level select high picks second target, low picks first.
// - event flags latch until read or reset.
// - bit 7 of configuration is a write-only reset trigger.
module bkreg_i2c_ctrl #(
  parameter int STARTUP_CYC = `BKREG_STARTUP_CYC
) (
  // clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clkEn,
  // serial bus pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // device pins and analog indications
  input  wire logic       enablePin,
  input  wire logic       supplyLow,
  input  wire logic       deepSupplyLoss,
  input  wire logic       levelSelectPin,
  input  wire logic       hsLimitTrip,
  input  wire logic       lsBelowLimit,
  input  wire logic       thermalTrip,
  input  wire logic       lightLoadSkipMode,
  input  wire logic       pwmHighReq,
  input  wire logic       powerBad,
  // switch control and regulator steering
  output logic            highSideOn,
  output logic            lowSideOn,
  output logic            outputDischargeOn,
  output logic            softStartReq,
  output logic [6:0]      activeTargetCode,
  output logic            forcedContinuousSwitching,
  output logic            regulatorRun
);

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  localparam logic [16:0] DLY_LOAD = 17'(STARTUP_CYC);

  bkreg_pkg::bkreg_state_t q;
  bkreg_pkg::bkreg_state_t d;
  bkreg_pkg::bkreg_ana_t   pins;
  logic                    sclRise;
  logic                    sclFall;
  logic                    startSeen;
  logic                    stopSeen;
  logic                    wrCommit;
  logic                    rdLoad;
  logic                    regRst;
  logic                    deviceOn;

  // byte a read returns for a pointer; unmapped reads as zero
  function automatic logic [7:0] readByte(input logic [7:0] p, input bkreg_pkg::bkreg_state_t s);
    logic [7:0] r;
    r = 8'h00;
    if (p == `BKREG_OFS_TGT_LOW) begin
      r = {1'b0, s.tgtLow};
    end else if (p == `BKREG_OFS_TGT_HIGH) begin
      r = s.tgtHigh;
    end else if (p == `BKREG_OFS_MISC_CFG) begin
      r = {1'b0, s.cfg};
    end else if (p == `BKREG_OFS_EVENTS) begin
      r = s.events;
    end
    return r;
  endfunction

  // gather pins for synchronising
  assign pins = '{scl: sclIn, sda: sdaIn, enable: enablePin, supplyLow: supplyLow,
                  deepSupplyLoss: deepSupplyLoss, levelSelect: levelSelectPin,
                  hsLimitTrip: hsLimitTrip, lsBelowLimit: lsBelowLimit, thermalTrip: thermalTrip,
                  skipMode: lightLoadSkipMode, pwmHighReq: pwmHighReq, powerBad: powerBad};

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  // edges come from the second stage only; the 5 ns clock oversamples a 1 MHz bus well
  always_comb begin
    d         = q;
    d.s1      = pins;
    d.s2      = q.s1;
    d.prev    = q.s2;
    sclRise   = q.s2.scl & ~q.prev.scl;
    sclFall   = ~q.s2.scl & q.prev.scl;
    // data is only looked at on edges, relying on SDA stable while SCL high
    startSeen = q.s2.scl & q.prev.scl & ~q.s2.sda & q.prev.sda;
    stopSeen  = q.s2.scl & q.prev.scl & q.s2.sda & ~q.prev.sda;
    wrCommit  = 1'b0;
    rdLoad    = 1'b0;

    // serial engine
    if (startSeen) begin
      d.st     = bkreg_pkg::ST_ADDR;
      d.bitCnt = 4'h0;
      d.sdaOe  = 1'b0;
    end else if (stopSeen) begin
      d.st     = bkreg_pkg::ST_IDLE;
      d.sdaOe  = 1'b0;
    end else begin
      case (q.st)
        bkreg_pkg::ST_ADDR, bkreg_pkg::ST_PTR, bkreg_pkg::ST_WDATA: begin
          if (sclRise) begin
            d.shIn   = {q.shIn[6:0], q.s2.sda};
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && q.bitCnt == 4'h8) begin
            d.bitCnt = 4'h0;
            if (q.st == bkreg_pkg::ST_ADDR) begin
              // only the matching address is acknowledged
              if (q.shIn[7:1] == `BKREG_TARGET_ADDR) begin
                d.st    = bkreg_pkg::ST_ADDR_ACK;
                d.sdaOe = 1'b1;
                d.rdDir = q.shIn[0];
              end else begin
                d.st = bkreg_pkg::ST_IDLE;
              end
            end else if (q.st == bkreg_pkg::ST_PTR) begin
              d.st    = bkreg_pkg::ST_PTR_ACK;
              d.ptr   = q.shIn;
              d.sdaOe = 1'b1;
            end else begin
              d.st    = bkreg_pkg::ST_WDAT_ACK;
              d.sdaOe = 1'b1;
            end
          end
        end
        bkreg_pkg::ST_ADDR_ACK: begin
          if (sclFall) begin
            if (q.rdDir) begin
              rdLoad  = 1'b1;
              d.st    = bkreg_pkg::ST_RDATA;
              d.shOut = readByte(q.ptr, q);
              d.sdaOe = ~d.shOut[7];
            end else begin
              d.st    = bkreg_pkg::ST_PTR;
              d.sdaOe = 1'b0;
            end
          end
        end
        bkreg_pkg::ST_PTR_ACK: begin
          if (sclFall) begin
            d.st    = bkreg_pkg::ST_WDATA;
            d.sdaOe = 1'b0;
          end
        end
        bkreg_pkg::ST_WDAT_ACK: begin
          if (sclFall) begin
            wrCommit = q.started;
            d.st     = bkreg_pkg::ST_WDATA;
            d.sdaOe  = 1'b0;
          end
        end
        bkreg_pkg::ST_RDATA: begin
          if (sclRise) begin
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (q.bitCnt == 4'h8) begin
              d.st     = bkreg_pkg::ST_RACK;
              d.bitCnt = 4'h0;
              d.sdaOe  = 1'b0;
            end else begin
              d.shOut = {q.shOut[6:0], 1'b0};
              d.sdaOe = ~q.shOut[6];
            end
          end
        end
        bkreg_pkg::ST_RACK: begin
          // controller acknowledges what it reads; a NACK ends the read
          if (sclRise) begin
            d.shIn = {q.shIn[6:0], q.s2.sda};
          end else if (sclFall) begin
            if (q.shIn[0]) begin
              d.st = bkreg_pkg::ST_IDLE;
            end else begin
              rdLoad  = 1'b1;
              d.st    = bkreg_pkg::ST_RDATA;
              d.shOut = readByte(q.ptr, q);
              d.sdaOe = ~d.shOut[7];
            end
          end
        end
        default: begin
          d.st = bkreg_pkg::ST_IDLE;
        end
      endcase
    end

    // register file; every reset source restores defaults
    regRst = q.s2.supplyLow | (q.prev.enable & ~q.s2.enable)
           | (wrCommit && q.ptr == `BKREG_OFS_MISC_CFG && q.shIn[`BKREG_CFG_RESET_BIT]);
    if (regRst) begin
      d.tgtLow  = `BKREG_RST_TGT_LOW;
      d.tgtHigh = `BKREG_RST_TGT_HIGH;
      d.cfg     = `BKREG_RST_MISC_CFG;
      d.events  = `BKREG_RST_EVENTS;
    end else if (wrCommit) begin
      if (q.ptr == `BKREG_OFS_TGT_LOW) begin
        d.tgtLow = q.shIn[6:0];
      end else if (q.ptr == `BKREG_OFS_TGT_HIGH) begin
        d.tgtHigh = q.shIn;
      end else if (q.ptr == `BKREG_OFS_MISC_CFG) begin
        d.cfg = q.shIn[6:0];
      end
    end

    // flags latch; a new event in the clearing cycle survives
    if (!regRst && rdLoad && q.ptr == `BKREG_OFS_EVENTS) begin
      d.events = 8'h00;
    end
    if (!regRst) begin
      d.events[`BKREG_EVT_THERMAL] = d.events[`BKREG_EVT_THERMAL] | d.thermOff;
      d.events[`BKREG_EVT_PWR_BAD] = d.events[`BKREG_EVT_PWR_BAD] | q.s2.powerBad;
    end

    // start-up delay; restarts on enable, supply recovery and reset bit
    deviceOn = q.s2.enable & ~q.s2.supplyLow & q.cfg[`BKREG_CFG_SW_EN];
    d.softStart = 1'b0;
    if (!q.s2.enable || q.s2.supplyLow || regRst) begin
      d.dlyCnt  = DLY_LOAD;
      d.started = 1'b0;
    end else if (!q.started) begin
      if (q.dlyCnt <= 17'h00001) begin
        d.started   = 1'b1;
        d.softStart = 1'b1;
      end else begin
        d.dlyCnt = q.dlyCnt - 17'h00001;
      end
    end

    // discharge choice frozen while disabled; deep loss forgets history
    if (q.s2.deepSupplyLoss) begin
      d.everEn   = 1'b0;
      d.dischLat = 1'b1;
    end else if (q.s2.enable) begin
      d.everEn   = 1'b1;
      d.dischLat = q.cfg[`BKREG_CFG_DISCH_EN];
    end
    d.dischOn = ~deviceOn & d.everEn & d.dischLat;

    // mode and target selection
    d.fcs     = q.cfg[`BKREG_CFG_FCS] | (q.s2.levelSelect & q.tgtHigh[`BKREG_HIGH_FCS_BIT]);
    d.actCode = q.s2.levelSelect ? q.tgtHigh[6:0] : q.tgtLow;

    // thermal trip ignored while skipping pulses at light load
    d.thermOff = q.s2.thermalTrip & ~(q.s2.skipMode & ~q.fcs);
    if (q.thermOff && !d.thermOff && deviceOn && q.started) begin
      d.softStart = 1'b1;
    end

    // current limit hold: low side carries the current down
    if (q.s2.hsLimitTrip) begin
      d.limAct = 1'b1;
    end else if (q.s2.lsBelowLimit) begin
      d.limAct = 1'b0;
    end
    d.run  = deviceOn & q.started & ~d.thermOff;
    d.hsOn = d.run & ~d.limAct & q.s2.pwmHighReq;
    d.lsOn = d.run & (d.limAct | ~q.s2.pwmHighReq);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // zero reset except state, registers, delay count, discharge latch and code; synchronisers start idle-high on the bus
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q          <= '0;
      q.s1.scl   <= 1'b1;
      q.s1.sda   <= 1'b1;
      q.s2.scl   <= 1'b1;
      q.s2.sda   <= 1'b1;
      q.prev.scl <= 1'b1;
      q.prev.sda <= 1'b1;
      q.st       <= bkreg_pkg::ST_IDLE;
      q.tgtLow   <= `BKREG_RST_TGT_LOW;
      q.tgtHigh  <= `BKREG_RST_TGT_HIGH;
      q.cfg      <= `BKREG_RST_MISC_CFG;
      q.dlyCnt   <= DLY_LOAD;
      q.dischLat <= 1'b1;
      q.actCode  <= `BKREG_RST_TGT_LOW;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // outputs straight from the state flops; SDA only ever pulled low
  assign sdaOut                    = 1'b0;
  assign sdaOe                     = q.sdaOe;
  assign highSideOn                = q.hsOn;
  assign lowSideOn                 = q.lsOn;
  assign outputDischargeOn         = q.dischOn;
  assign softStartReq              = q.softStart;
  assign activeTargetCode          = q.actCode;
  assign forcedContinuousSwitching = q.fcs;
  assign regulatorRun              = q.run;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !clkEn);

  AST_ADDR_ACK: assert property ($rose(q.sdaOe) && q.st == bkreg_pkg::ST_ADDR_ACK
    |-> $past(q.shIn[7:1]) == `BKREG_TARGET_ADDR) else $error("ack given to foreign address");
  AST_START: assert property (startSeen |=> q.st == bkreg_pkg::ST_ADDR && q.bitCnt == 4'h0)
    else $error("start not followed by address phase");
  AST_STOP: assert property (stopSeen && !startSeen |=> q.st == bkreg_pkg::ST_IDLE && !sdaOe)
    else $error("stop did not release bus");
  AST_COMMIT: assert property (wrCommit |-> sclFall && q.st == bkreg_pkg::ST_WDAT_ACK && q.started)
    else $error("write committed outside acknowledge fall");
  AST_UNMAPPED: assert property (rdLoad && q.ptr != `BKREG_OFS_TGT_LOW && q.ptr != `BKREG_OFS_TGT_HIGH
    && q.ptr != `BKREG_OFS_MISC_CFG && q.ptr != `BKREG_OFS_EVENTS |=> q.shOut == 8'h00 && sdaOe)
    else $error("unmapped read not zero");
  AST_FLAG_CLR: assert property (rdLoad && q.ptr == `BKREG_OFS_EVENTS && !regRst
    |=> q.events == {3'b000, $past(d.thermOff), 1'b0, $past(q.s2.powerBad), 2'b00})
    else $error("flags not cleared on read");
  AST_EN_FALL: assert property (q.prev.enable && !q.s2.enable |=> q.tgtLow == `BKREG_RST_TGT_LOW
    && q.cfg == `BKREG_RST_MISC_CFG && !q.started) else $error("enable fall left registers");
  AST_SUPPLY: assert property (q.s2.supplyLow |=> q.tgtHigh == `BKREG_RST_TGT_HIGH && !regulatorRun)
    else $error("supply low did not reset");
  AST_LIMIT: assert property (q.s2.hsLimitTrip |=> !highSideOn && lowSideOn == regulatorRun)
    else $error("high side on during limit");
  AST_THERMAL: assert property (d.thermOff |=> !highSideOn && !lowSideOn)
    else $error("switch on in thermal trip");
  AST_DISCH: assert property (outputDischargeOn |-> q.everEn && !regulatorRun)
    else $error("discharge without prior enable");
  AST_SELECT: assert property ($changed(q.s2.levelSelect) ##1 !$changed(q.s2.levelSelect)
    |-> activeTargetCode == (q.prev.levelSelect ? $past(q.tgtHigh[6:0]) : $past(q.tgtLow)))
    else $error("target not following select");
  AST_NO_WR_EARLY: assert property (!q.started && q.st == bkreg_pkg::ST_WDAT_ACK && sclFall
    |=> $stable(q.tgtLow) && $stable(q.tgtHigh)) else $error("write during start-up delay");

  COV_WRITE: cover property (wrCommit && q.ptr == `BKREG_OFS_TGT_LOW);
  COV_READ: cover property (rdLoad && q.ptr == `BKREG_OFS_EVENTS);
  COV_LIMIT: cover property (q.limAct ##[1:50] !q.limAct);
  COV_THERM: cover property (q.thermOff ##[1:50] softStartReq);

endmodule

// >>> tb/bkreg_i2c_master.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// bus controller model: plain F/S framing, SCL still between frames
// ----------------------------------------------------------------------
module bkreg_i2c_master #(
  parameter int QTR = 8
) (
  // clock
  input  wire logic clk_sys,
  // bus wires, open drain with pull-ups
  input  wire logic sdaWire,
  output logic      sclHi,
  output logic      sdaPull
);
  // both lines released while idle
  initial begin
    sclHi   = 1'b1;
    sdaPull = 1'b0;
  end

  // quarter of a 160 ns link period; changes land just after an edge
  task automatic wq(input int n);
    repeat (n * QTR) @(posedge clk_sys);
    #1;
  endtask

  // start or repeated start, never the high-speed preamble
  task automatic start();
    sdaPull = 1'b0;
    wq(1);
    sclHi = 1'b1;
    wq(2);
    sdaPull = 1'b1;
    wq(2);
    sclHi = 1'b0;
    wq(1);
  endtask

  // stop: SDA released while SCL high
  task automatic stop();
    sdaPull = 1'b1;
    wq(1);
    sclHi = 1'b1;
    wq(2);
    sdaPull = 1'b0;
    wq(2);
  endtask

  // data set in the low phase, held through the whole high phase
  task automatic bitx(input logic b, output logic r);
    sdaPull = !b;
    wq(1);
    sclHi = 1'b1;
    wq(2);
    r = sdaWire;
    sclHi = 1'b0;
    wq(1);
  endtask

  // msb first, then the ninth clock; a=0 acks a byte read from the target
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(a, k);
  endtask
endmodule

// >>> tb/bkreg_i2c_ctrl_tb.sv
`timescale 1ns/1ps
module bkreg_i2c_ctrl_tb;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam int SU = 2000;  // long enough that a write lands inside start-up
  logic       clk_sys, rst, enablePin, supplyLow, levelSelectPin;
  logic       hsLimitTrip, lsBelowLimit, thermalTrip, powerBad, deepSupplyLoss, lightLoadSkipMode;
  logic       sdaOut, sdaOe, sclHi, sdaPull, highSideOn, lowSideOn;
  logic       outputDischargeOn, softStartReq, forcedContinuousSwitching, regulatorRun;
  logic [6:0] activeTargetCode;
  logic [7:0] q, lo, hi;
  logic       k;
  int         n_mismatch, checked;
  // wire level: either party pulls low, pull-up otherwise
  wire        sdaWire = !(sdaOe | sdaPull);

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  bkreg_i2c_ctrl #(.STARTUP_CYC(SU)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .sclIn(sclHi), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .enablePin(enablePin), .supplyLow(supplyLow),
    .deepSupplyLoss(deepSupplyLoss), .levelSelectPin(levelSelectPin), .hsLimitTrip(hsLimitTrip),
    .lsBelowLimit(lsBelowLimit), .thermalTrip(thermalTrip), .lightLoadSkipMode(lightLoadSkipMode),
    .pwmHighReq(1'b1), .powerBad(powerBad), .highSideOn(highSideOn), .lowSideOn(lowSideOn),
    .outputDischargeOn(outputDischargeOn), .softStartReq(softStartReq),
    .activeTargetCode(activeTargetCode), .forcedContinuousSwitching(forcedContinuousSwitching),
    .regulatorRun(regulatorRun));

  bkreg_i2c_master mst (.clk_sys(clk_sys), .sdaWire(sdaWire), .sclHi(sclHi), .sdaPull(sdaPull));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chkv({7'h00, got}, {7'h00, exp});
  endtask

  task automatic final_report();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // 7-bit code that the level select should steer out
  function automatic logic [7:0] expTgt(input logic s, input logic [7:0] a, input logic [7:0] b);
    return s ? {1'b0, b[6:0]} : {1'b0, a[6:0]};
  endfunction

  // address with write direction, then the pointer byte
  task automatic hdr(input logic [7:0] p);
    mst.start();
    mst.xfer(8'h80, 1'b1, q, k);
    chkb(k, 1'b0);
    mst.xfer(p, 1'b1, q, k);
    chkb(k, 1'b0);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    hdr(p);
    mst.xfer(d, 1'b1, q, k);
    chkb(k, 1'b0);
    mst.stop();
  endtask

  // pointer write, repeated start, one byte read and refused
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    hdr(p);
    mst.start();
    mst.xfer(8'h81, 1'b1, q, k);
    mst.xfer(8'hff, 1'b1, q, k);
    chkv(q, e);
    mst.stop();
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst, enablePin, supplyLow, levelSelectPin} = 4'b1000;
    {hsLimitTrip, lsBelowLimit, thermalTrip, powerBad, deepSupplyLoss, lightLoadSkipMode} = 6'h00;
    n_mismatch = 0;
    checked    = 0;
    lo = 8'($urandom(32'h90a051f9));
    cyc(12);
    rst = 1'b0;
    cyc(10);
    chkb(outputDischargeOn, 1'b0);
    enablePin = 1'b1;
    mst.stop();
    cyc(SU + 20);
    rd(8'h01, 8'h10);
    rd(8'h02, 8'h38);
    rd(8'h03, 8'h6b);
    rd(8'h05, 8'h00);
    for (int i = 0; i < 8; i++) begin
      if (!(i inside {1, 2, 3, 5})) rd(8'(i), 8'h00);
    end
    // foreign address is left unanswered
    mst.start();
    mst.xfer(8'h82, 1'b1, q, k);
    chkb(k, 1'b1);
    mst.stop();
    // random codes, edges of the code range first
    for (int i = 0; i < 4; i++) begin
      lo = (i == 0) ? 8'hff : 8'($urandom);
      hi = (i == 0) ? 8'h00 : 8'($urandom);
      wr(8'h01, lo);
      wr(8'h02, hi);
      rd(8'h01, {1'b0, lo[6:0]});
      rd(8'h02, hi);
      levelSelectPin = 1'($urandom);
      cyc(8);
      chkv({1'b0, activeTargetCode}, expTgt(levelSelectPin, lo, hi));
    end
    // controller acks, so the same register comes again
    hdr(8'h02);
    mst.start();
    mst.xfer(8'h81, 1'b1, q, k);
    mst.xfer(8'hff, 1'b0, q, k);
    chkv(q, hi);
    mst.xfer(8'hff, 1'b1, q, k);
    chkv(q, hi);
    mst.stop();
    // latched flags, thermal off and soft restart
    powerBad = 1'b1;
    cyc(2);
    powerBad    = 1'b0;
    thermalTrip = 1'b1;
    cyc(8);
    chkb(highSideOn | lowSideOn, 1'b0);
    thermalTrip = 1'b0;
    for (int i = 0; i < 40 && softStartReq !== 1'b1; i++) cyc(1);
    chkb(softStartReq, 1'b1);
    if (softStartReq !== 1'b1) final_report();
    rd(8'h05, 8'h14);
    rd(8'h05, 8'h00);
    // current limit swap and swap back
    hsLimitTrip = 1'b1;
    cyc(6);
    chkb(highSideOn, 1'b0);
    chkb(lowSideOn, 1'b1);
    hsLimitTrip  = 1'b0;
    lsBelowLimit = 1'b1;
    cyc(6);
    chkb(highSideOn, 1'b1);
    lsBelowLimit = 1'b0;
    // reset bit: defaults back, writes dropped during start-up
    wr(8'h01, 8'h22);
    wr(8'h03, 8'h80);
    wr(8'h01, 8'h33);
    rd(8'h01, 8'h10);
    rd(8'h03, 8'h6b);
    cyc(SU + 10);
    // supply dip
    wr(8'h02, 8'h05);
    supplyLow = 1'b1;
    cyc(6);
    supplyLow = 1'b0;
    cyc(SU + 10);
    rd(8'h02, 8'h38);
    // pulse skipping at light load masks the thermal trip
    lightLoadSkipMode = 1'b1;
    thermalTrip       = 1'b1;
    cyc(8);
    chkb(regulatorRun, 1'b1);
    chkb(forcedContinuousSwitching, 1'b0);
    chkb(sdaOut, 1'b0);
    {lightLoadSkipMode, thermalTrip} = 2'b00;
    cyc(4);
    // enable fall: defaults and discharge
    wr(8'h02, 8'h05);
    enablePin = 1'b0;
    cyc(6);
    chkb(outputDischargeOn, 1'b1);
    rd(8'h02, 8'h38);
    // deep supply loss forgets the enable history
    deepSupplyLoss = 1'b1;
    cyc(6);
    chkb(outputDischargeOn, 1'b0);
    final_report();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end
endmodule
